// *** shared/image_map_pkg.sv ***
// Constants for the fieldbus cyclic I/O image mapper.
// Assumes a single 10 MHz clock and an APB register port.
package image_map_pkg;
	// Image length selections
	localparam logic [1:0] LEN_BASIC = 2'h0;
	localparam logic [1:0] LEN_EXT1 = 2'h1;
	localparam logic [1:0] LEN_EXT2 = 2'h2;
	localparam logic [5:0] BYTES_BASIC = 6'h06;
	localparam logic [5:0] BYTES_EXT1 = 6'h20;
	localparam logic [5:0] BYTES_EXT2 = 6'h0c;
	// Message area bases and handshake byte positions
	localparam logic [4:0] MSG_BASE_EXT1 = 5'h10;
	localparam logic [4:0] MSG_HS_EXT1 = 5'h1f;
	localparam logic [4:0] MSG_BASE_EXT2 = 5'h04;
	localparam logic [4:0] MSG_HS_EXT2 = 5'h0b;
	// Setting codes
	localparam logic [1:0] CM_VF = 2'h0;
	localparam logic [1:0] CM_VF_ENC = 2'h1;
	localparam logic [1:0] CM_CLV = 2'h3;
	localparam logic [2:0] AO_THROUGH = 3'h0;
	localparam logic [3:0] DO_THROUGH = 4'hf;
	localparam logic [15:0] CURRENT_COARSE_DIV = 16'h000a;
	// APB register byte offsets
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_FUNC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	// Config register fields
	localparam int CFG_FMT = 0;
	localparam int CFG_LEN_LO = 1;
	localparam int CFG_CM_LO = 3;
	localparam int CFG_TNS = 5;
	localparam int CFG_TMODE = 6;
	localparam int CFG_LARGE = 7;
	// Function register fields
	localparam int FN_FM_LO = 0;
	localparam int FN_AM_LO = 3;
	localparam int FN_RELAY_LO = 8;
	localparam int FN_OC1_LO = 12;
	localparam int FN_OC2_LO = 16;
	// Reset values
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
	// Fast data forwarding deadline
	localparam int CLK_PERIOD_NS = 100;
	localparam int FAST_FWD_MAX_NS = 2000000;
	localparam int FAST_FWD_CYCLES = FAST_FWD_MAX_NS / CLK_PERIOD_NS;
endpackage : image_map_pkg

// *** hdl/fieldbus_io_image_mapper.sv ***
// Cyclic I/O image mapper between a fieldbus byte stream and drive words.
// Assumes bytes arrive synchronous to clock_in, one per valid cycle.
`timescale 1ns/1ns
module fieldbus_io_image_mapper #(
	parameter int FWD_CYCLES = image_map_pkg::FAST_FWD_CYCLES
) (
	input wire logic clock_in,
	input wire logic srst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Output image stream from master
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_last_in,
	// Input image byte reads toward master
	input wire logic tx_rd_in,
	input wire logic [4:0] tx_index_in,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	// Drive command side
	output logic cmd_update_out,
	output logic [15:0] op_command_out,
	output logic [15:0] freq_ref_out,
	output logic [15:0] torque_ref_out,
	output logic [15:0] torque_limit_out,
	output logic [15:0] torque_comp_out,
	output logic [15:0] analog_out1_out,
	output logic [15:0] analog_out2_out,
	output logic relay_out,
	output logic open_collector1_out,
	output logic open_collector2_out,
	// Drive monitor side
	input wire logic [15:0] drive_status_in,
	input wire logic [15:0] motor_speed_in,
	input wire logic [15:0] output_freq_in,
	input wire logic [15:0] output_current_in,
	input wire logic [15:0] torque_monitor_in,
	input wire logic [15:0] encoder_count_in,
	input wire logic [15:0] freq_ref_monitor_in,
	input wire logic [15:0] analog_in_in,
	// Message area toward the drive's message engine
	output logic msg_req_out,
	output logic [7:0] msg_func_out,
	output logic [15:0] msg_addr_out,
	output logic [7:0] msg_count_out,
	output logic [63:0] msg_data_out,
	input wire logic msg_done_in,
	input wire logic [7:0] msg_rep_func_in,
	input wire logic [15:0] msg_rep_addr_in,
	input wire logic [7:0] msg_rep_count_in,
	input wire logic [63:0] msg_rep_data_in
);
	// ****************************************
	// Settings registers
	// ****************************************
	logic [31:0] config_ff; // Format, length, control method, torque
	logic [31:0] func_ff; // Analog and digital output functions
	logic apb_wr; // Completing write
	logic apb_hit; // Address maps to a register
	logic fmt_conv; // Conventional layouts selected
	logic [1:0] len_sel; // Image length selection
	logic [1:0] cm; // Control method select
	logic is_vf; // Volts-per-hertz control
	logic [5:0] img_bytes; // Bytes in the configured image
	logic msg_busy_ff; // Message handed to the drive
	logic [7:0] hs_taken_ff; // Handshake of the last request taken
	logic [7:0] hs_reply_ff; // Handshake returned with the reply

	assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
	assign apb_hit = (paddr_in == image_map_pkg::REG_CONFIG) ||
		(paddr_in == image_map_pkg::REG_FUNC) ||
		(paddr_in == image_map_pkg::REG_STATUS);
	assign fmt_conv = config_ff[image_map_pkg::CFG_FMT];
	assign len_sel = config_ff[image_map_pkg::CFG_LEN_LO +: 2];
	assign cm = config_ff[image_map_pkg::CFG_CM_LO +: 2];
	assign is_vf = (cm == image_map_pkg::CM_VF) ||
		(cm == image_map_pkg::CM_VF_ENC);

	// Image length from the master's configuration
	always_comb begin
		case (len_sel)
			image_map_pkg::LEN_EXT1: img_bytes = image_map_pkg::BYTES_EXT1;
			image_map_pkg::LEN_EXT2: img_bytes = image_map_pkg::BYTES_EXT2;
			default: img_bytes = image_map_pkg::BYTES_BASIC;
		endcase
	end

	// Register writes
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			config_ff <= image_map_pkg::CONFIG_RESET;
			func_ff <= image_map_pkg::FUNC_RESET;
		end else if (apb_wr) begin
			if (paddr_in == image_map_pkg::REG_CONFIG) begin
				config_ff <= {24'h000000, pwdata_in[7:0]};
			end else if (paddr_in == image_map_pkg::REG_FUNC) begin
				func_ff <= {12'h000, pwdata_in[19:8], 2'h0, pwdata_in[5:0]};
			end
		end
	end

	// APB answer: no wait states, read data and error with pready
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~apb_hit;
			if (psel_in & ~penable_in & ~pwrite_in) begin
				case (paddr_in)
					image_map_pkg::REG_CONFIG: prdata_out <= config_ff;
					image_map_pkg::REG_FUNC: prdata_out <= func_ff;
					image_map_pkg::REG_STATUS: prdata_out <= {15'h0000,
						msg_busy_ff, hs_reply_ff, hs_taken_ff};
					default: prdata_out <= 32'h0000_0000;
				endcase
			end else begin
				prdata_out <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Output image capture
	// ****************************************
	logic [7:0] rx_buf [0:31]; // Staging copy of the output image
	logic [5:0] rx_idx_ff; // Next byte position
	logic [15:0] fwd_cnt_ff; // Cycles since frame's first byte
	logic commit_ff; // Decode staging copy this cycle
	logic frame_open; // Bytes held but not yet decoded

	assign frame_open = (rx_idx_ff != 6'h00);

	// Store bytes inside the image length; excess bytes dropped
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rx_idx_ff <= 6'h00;
		end else if (rx_valid_in) begin
			if (rx_last_in) begin
				rx_idx_ff <= 6'h00;
			end else if (rx_idx_ff != 6'h3f) begin
				rx_idx_ff <= rx_idx_ff + 6'h01;
			end
		end else if (fwd_cnt_ff >= 16'(FWD_CYCLES - 1)) begin
			rx_idx_ff <= 6'h00;
		end
	end

	// Staging array write
	always_ff @(posedge clock_in) begin
		if (rx_valid_in && (rx_idx_ff < img_bytes)) begin
			rx_buf[rx_idx_ff[4:0]] <= rx_byte_in;
		end
	end

	// Deadline counter: a frame never closed is decoded in the first cycle without a byte from the deadline on
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			fwd_cnt_ff <= 16'h0000;
			commit_ff <= 1'b0;
		end else begin
			commit_ff <= (rx_valid_in & rx_last_in) |
				(frame_open & ~rx_valid_in &
				(fwd_cnt_ff >= 16'(FWD_CYCLES - 1)));
			if ((rx_valid_in & rx_last_in) || commit_ff) begin
				fwd_cnt_ff <= 16'h0000;
			end else if (frame_open || rx_valid_in) begin
				fwd_cnt_ff <= fwd_cnt_ff + 16'h0001;
			end
		end
	end

	// Big-endian word from two staged bytes
	function automatic logic [15:0] word_at(input logic [4:0] idx);
		word_at = {rx_buf[idx], rx_buf[idx + 5'h01]};
	endfunction : word_at

	// ****************************************
	// Fast data decode toward the drive
	// ****************************************
	logic take_torque; // Network torque accepted
	logic [15:0] torque_field; // Torque field of the image

	assign take_torque = (cm == image_map_pkg::CM_CLV) &&
		config_ff[image_map_pkg::CFG_TNS];
	// Bytes read directly: an assign calling a function misses array updates
	assign torque_field = {rx_buf[5'h04], rx_buf[5'h05]};

	// Command, reference and torque words
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cmd_update_out <= 1'b0;
			op_command_out <= 16'h0000;
			freq_ref_out <= 16'h0000;
			torque_ref_out <= 16'h0000;
			torque_limit_out <= 16'h0000;
			torque_comp_out <= 16'h0000;
		end else begin
			cmd_update_out <= commit_ff & fmt_conv;
			if (commit_ff && fmt_conv) begin
				op_command_out <= word_at(5'h00);
				freq_ref_out <= word_at(5'h02);
				// Extended two carries no torque field
				if (take_torque && (len_sel != image_map_pkg::LEN_EXT2)) begin
					if (config_ff[image_map_pkg::CFG_TMODE]) begin
						torque_ref_out <= torque_field;
					end else begin
						torque_limit_out <= torque_field;
					end
				end
				// Compensation is in extended one only
				if ((cm == image_map_pkg::CM_CLV) &&
						(len_sel == image_map_pkg::LEN_EXT1)) begin
					torque_comp_out <= word_at(5'h06);
				end
			end
		end
	end

	// Analog and digital outputs, extended one only
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			analog_out1_out <= 16'h0000;
			analog_out2_out <= 16'h0000;
			relay_out <= 1'b0;
			open_collector1_out <= 1'b0;
			open_collector2_out <= 1'b0;
		end else if (commit_ff && fmt_conv &&
				(len_sel == image_map_pkg::LEN_EXT1)) begin
			// Bytes 8 and 9 are skipped
			if (func_ff[image_map_pkg::FN_FM_LO +: 3] ==
					image_map_pkg::AO_THROUGH) begin
				analog_out1_out <= word_at(5'h0a);
			end
			if (func_ff[image_map_pkg::FN_AM_LO +: 3] ==
					image_map_pkg::AO_THROUGH) begin
				analog_out2_out <= word_at(5'h0c);
			end
			if (func_ff[image_map_pkg::FN_RELAY_LO +: 4] ==
					image_map_pkg::DO_THROUGH) begin
				relay_out <= rx_buf[5'h0f][0];
			end
			if (func_ff[image_map_pkg::FN_OC1_LO +: 4] ==
					image_map_pkg::DO_THROUGH) begin
				open_collector1_out <= rx_buf[5'h0f][1];
			end
			if (func_ff[image_map_pkg::FN_OC2_LO +: 4] ==
					image_map_pkg::DO_THROUGH) begin
				open_collector2_out <= rx_buf[5'h0f][2];
			end
		end
	end

	// ****************************************
	// Message area and handshake
	// ****************************************
	logic has_msg; // Format carries a message area
	logic [4:0] msg_base; // First message byte
	logic [7:0] hs_in; // Handshake byte from the master
	logic [7:0] rep_func_ff; // Reply function code
	logic [15:0] rep_addr_ff; // Reply start address
	logic [7:0] rep_count_ff; // Reply data count
	logic [63:0] rep_data_ff; // Reply data words

	assign has_msg = (len_sel == image_map_pkg::LEN_EXT1) ||
		(len_sel == image_map_pkg::LEN_EXT2);
	assign msg_base = (len_sel == image_map_pkg::LEN_EXT1) ?
		image_map_pkg::MSG_BASE_EXT1 : image_map_pkg::MSG_BASE_EXT2;
	assign hs_in = (len_sel == image_map_pkg::LEN_EXT1) ?
		rx_buf[image_map_pkg::MSG_HS_EXT1] :
		rx_buf[image_map_pkg::MSG_HS_EXT2];

	// New handshake value starts a request; reply echoes it back
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			msg_req_out <= 1'b0;
			msg_busy_ff <= 1'b0;
			hs_taken_ff <= 8'h00;
			msg_func_out <= 8'h00;
			msg_addr_out <= 16'h0000;
			msg_count_out <= 8'h00;
			msg_data_out <= 64'h0;
		end else begin
			msg_req_out <= 1'b0;
			if (msg_busy_ff && msg_done_in) begin
				msg_busy_ff <= 1'b0;
			end else if (commit_ff && fmt_conv && has_msg && !msg_busy_ff &&
					(hs_in != hs_taken_ff)) begin
				msg_req_out <= 1'b1;
				msg_busy_ff <= 1'b1;
				hs_taken_ff <= hs_in;
				msg_func_out <= rx_buf[msg_base];
				msg_addr_out <= word_at(msg_base + 5'h01);
				msg_count_out <= rx_buf[msg_base + 5'h03];
				if (len_sel == image_map_pkg::LEN_EXT1) begin
					msg_data_out <= {word_at(5'h14), word_at(5'h16),
						word_at(5'h18), word_at(5'h1a)};
				end else begin
					msg_data_out <= {word_at(5'h08), 48'h0};
				end
			end
		end
	end

	// Reply capture
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			hs_reply_ff <= 8'h00;
			rep_func_ff <= 8'h00;
			rep_addr_ff <= 16'h0000;
			rep_count_ff <= 8'h00;
			rep_data_ff <= 64'h0;
		end else if (msg_busy_ff && msg_done_in) begin
			hs_reply_ff <= hs_taken_ff;
			rep_func_ff <= msg_rep_func_in;
			rep_addr_ff <= msg_rep_addr_in;
			rep_count_ff <= msg_rep_count_in;
			rep_data_ff <= msg_rep_data_in;
		end
	end

	// ****************************************
	// Input image toward the master
	// ****************************************
	logic [15:0] cur_word; // Scaled output current
	logic [15:0] speed_word; // Speed field for this format
	logic [15:0] tmon_word; // Torque monitor or zero
	logic [7:0] nxt_tx_byte; // Byte at the requested position

	// Current step 0.01 A small drives, 0.1 A large drives
	assign cur_word = config_ff[image_map_pkg::CFG_LARGE] ?
		(output_current_in / image_map_pkg::CURRENT_COARSE_DIV) :
		output_current_in;
	assign tmon_word = is_vf ? 16'h0000 : torque_monitor_in;

	// Speed field: V/f substitution differs per format
	always_comb begin
		speed_word = motor_speed_in;
		if (is_vf) begin
			if (len_sel == image_map_pkg::LEN_EXT1) begin
				speed_word = 16'h0000;
			end else begin
				speed_word = output_freq_in;
			end
		end
	end

	// Byte mux, high byte first for every pair
	always_comb begin
		nxt_tx_byte = 8'h00;
		if (!fmt_conv || ({1'b0, tx_index_in} >= img_bytes)) begin
			nxt_tx_byte = 8'h00;
		end else begin
			case (tx_index_in)
				5'h00: nxt_tx_byte = drive_status_in[15:8];
				5'h01: nxt_tx_byte = drive_status_in[7:0];
				5'h02: nxt_tx_byte = speed_word[15:8];
				5'h03: nxt_tx_byte = speed_word[7:0];
				default: nxt_tx_byte = 8'h00;
			endcase
			case (len_sel)
				image_map_pkg::LEN_BASIC: begin
					if (tx_index_in == 5'h04) begin
						nxt_tx_byte = cur_word[15:8];
					end else if (tx_index_in == 5'h05) begin
						nxt_tx_byte = cur_word[7:0];
					end
				end
				image_map_pkg::LEN_EXT1: begin
					case (tx_index_in)
						5'h04: nxt_tx_byte = tmon_word[15:8];
						5'h05: nxt_tx_byte = tmon_word[7:0];
						5'h06: nxt_tx_byte = encoder_count_in[15:8];
						5'h07: nxt_tx_byte = encoder_count_in[7:0];
						5'h08: nxt_tx_byte = freq_ref_monitor_in[15:8];
						5'h09: nxt_tx_byte = freq_ref_monitor_in[7:0];
						5'h0a: nxt_tx_byte = output_freq_in[15:8];
						5'h0b: nxt_tx_byte = output_freq_in[7:0];
						5'h0c: nxt_tx_byte = cur_word[15:8];
						5'h0d: nxt_tx_byte = cur_word[7:0];
						5'h0e: nxt_tx_byte = analog_in_in[15:8];
						5'h0f: nxt_tx_byte = analog_in_in[7:0];
						5'h10: nxt_tx_byte = rep_func_ff;
						5'h11: nxt_tx_byte = rep_addr_ff[15:8];
						5'h12: nxt_tx_byte = rep_addr_ff[7:0];
						5'h13: nxt_tx_byte = rep_count_ff;
						5'h14: nxt_tx_byte = rep_data_ff[63:56];
						5'h15: nxt_tx_byte = rep_data_ff[55:48];
						5'h16: nxt_tx_byte = rep_data_ff[47:40];
						5'h17: nxt_tx_byte = rep_data_ff[39:32];
						5'h18: nxt_tx_byte = rep_data_ff[31:24];
						5'h19: nxt_tx_byte = rep_data_ff[23:16];
						5'h1a: nxt_tx_byte = rep_data_ff[15:8];
						5'h1b: nxt_tx_byte = rep_data_ff[7:0];
						5'h1f: nxt_tx_byte = hs_reply_ff;
						default: begin
							if (tx_index_in > 5'h03) begin
								nxt_tx_byte = 8'h00;
							end
						end
					endcase
				end
				image_map_pkg::LEN_EXT2: begin
					case (tx_index_in)
						5'h04: nxt_tx_byte = rep_func_ff;
						5'h05: nxt_tx_byte = rep_addr_ff[15:8];
						5'h06: nxt_tx_byte = rep_addr_ff[7:0];
						5'h07: nxt_tx_byte = rep_count_ff;
						5'h08: nxt_tx_byte = rep_data_ff[63:56];
						5'h09: nxt_tx_byte = rep_data_ff[55:48];
						5'h0b: nxt_tx_byte = hs_reply_ff;
						default: begin
							if (tx_index_in > 5'h03) begin
								nxt_tx_byte = 8'h00;
							end
						end
					endcase
				end
				default: nxt_tx_byte = 8'h00;
			endcase
		end
	end

	// Registered byte answer one cycle after the read
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			tx_byte_out <= 8'h00;
			tx_valid_out <= 1'b0;
		end else begin
			tx_valid_out <= tx_rd_in;
			tx_byte_out <= tx_rd_in ? nxt_tx_byte : 8'h00;
		end
	end
endmodule : fieldbus_io_image_mapper

// *** tb/img_map_asserts.sv ***
// Checker for the image mapper, bound onto its ports.
// Assumes config writes reach the mapper only over its APB port.
`timescale 1ns/1ns
module img_map_asserts (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic rx_valid_in,
	input wire logic rx_last_in,
	input wire logic tx_rd_in,
	input wire logic [4:0] tx_index_in,
	input wire logic [7:0] tx_byte_out,
	input wire logic tx_valid_out,
	input wire logic cmd_update_out,
	input wire logic msg_req_out,
	input wire logic [15:0] drive_status_in
);
	// ****************
	// Config shadow
	// ****************
	logic [7:0] cfg_ff; // Copy of the config byte
	logic [7:0] stat_hi; // Status high byte
	logic wr_cfg; // Config write completes
	assign stat_hi = drive_status_in[15:8];
	assign wr_cfg = psel_in && penable_in && pready_out && pwrite_in
		&& paddr_in == image_map_pkg::REG_CONFIG;
	// Follow completed config writes
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cfg_ff <= 8'h00;
		end else if (wr_cfg) begin
			cfg_ff <= pwdata_in[7:0];
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	// ****************
	// Properties
	// ****************
	property p_apb_wait;
		psel_in && !penable_in |=> pready_out;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("no ready");
	property p_unmapped;
		psel_in && !penable_in && !(paddr_in inside {8'h00, 8'h04, 8'h08})
			|=> pslverr_out && pready_out;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error");
	property p_fwd;
		rx_valid_in && rx_last_in && cfg_ff[0] |-> ##2 cmd_update_out;
	endproperty
	a_fwd: assert property (p_fwd) else $error("late update");
	property p_fmt0;
		tx_valid_out && !cfg_ff[0] |-> tx_byte_out == 8'h00;
	endproperty
	a_fmt0: assert property (p_fmt0) else $error("profile byte");
	property p_txv;
		tx_rd_in |=> tx_valid_out;
	endproperty
	a_txv: assert property (p_txv) else $error("no tx valid");
	property p_status;
		tx_rd_in && cfg_ff[0] && tx_index_in == 5'h00
			|=> tx_byte_out == $past(stat_hi);
	endproperty
	a_status: assert property (p_status) else $error("status");
	property p_e1spd;
		tx_rd_in && cfg_ff[2:0] == 3'h3 && !cfg_ff[4]
			&& tx_index_in inside {[2:5]} |=> tx_byte_out == 8'h00;
	endproperty
	a_e1spd: assert property (p_e1spd) else $error("vf");
	property p_resv;
		tx_rd_in && cfg_ff[0] && ((cfg_ff[2:1] == 2'h0 && tx_index_in > 5)
			|| (cfg_ff[2:1] == 2'h1 && tx_index_in inside {[28:30]}))
			|=> tx_byte_out == 8'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	property p_msg;
		msg_req_out |-> cmd_update_out;
	endproperty
	a_msg: assert property (p_msg) else $error("lone request");
endmodule : img_map_asserts

// *** tb/fb_master_model.sv ***
// Fieldbus master model: sends output images, reads input bytes.
// Assumes the bench calls its tasks; lines change after rising edges.
`timescale 1ns/1ns
module fb_master_model (
	input wire logic clock_in,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out,
	output logic rx_last_out,
	output logic tx_rd_out,
	output logic [4:0] tx_index_out,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in
);
	// Idle lines at time zero
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		rx_last_out = 1'b0;
		tx_rd_out = 1'b0;
		tx_index_out = 5'h00;
	end
	// Counting bytes from base; the handshake byte is set by base, not by replies
	task send(input int n, input logic [7:0] base, input bit last);
		for (int i = 0; i < n; i++) begin
			@(posedge clock_in);
			rx_valid_out <= 1'b1;
			rx_byte_out <= base + 8'(i);
			rx_last_out <= last && i == n - 1;
		end
		@(posedge clock_in);
		rx_valid_out <= 1'b0;
		rx_last_out <= 1'b0;
		rx_byte_out <= ~rx_byte_out; // Released data is not kept
	endtask : send
	// One input image byte read
	task get(input logic [4:0] idx, output logic [7:0] b);
		@(posedge clock_in);
		tx_rd_out <= 1'b1;
		tx_index_out <= idx;
		@(posedge clock_in);
		tx_rd_out <= 1'b0;
		tx_index_out <= ~idx;
		// Answer taken at the edge that closes its cycle
		@(posedge clock_in);
		b = tx_valid_in ? tx_byte_in : 8'hxx;
	endtask : get
endmodule : fb_master_model

// *** tb/tb.sv ***
// Testbench top for the image mapper with a master model.
// Assumes the package is compiled first; checker bound below.
`timescale 1ns/1ns
module tb;
	`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
		err_count++; $display("ERROR %s exp %0h got %0h", nm, ex, got); \
		end end
	logic clock_in, srst_in, psel_in, penable_in, pwrite_in, rx_valid_in;
	logic rx_last_in, tx_rd_in, pready_out, pslverr_out, tx_valid_out;
	logic cmd_update_out, msg_req_out, relay_out, msg_done_in;
	logic open_collector1_out, open_collector2_out;
	logic [7:0] paddr_in, rx_byte_in, tx_byte_out, msg_func_out, b;
	logic [7:0] msg_count_out, msg_rep_func_in, msg_rep_count_in;
	logic [4:0] tx_index_in;
	logic [31:0] pwdata_in, prdata_out, rd_v;
	logic [15:0] op_command_out, freq_ref_out, torque_ref_out;
	logic [15:0] torque_limit_out, torque_comp_out, analog_out1_out;
	logic [15:0] analog_out2_out, msg_addr_out, drive_status_in;
	logic [15:0] motor_speed_in, output_freq_in, output_current_in;
	logic [15:0] torque_monitor_in, encoder_count_in, freq_ref_monitor_in;
	logic [15:0] analog_in_in, msg_rep_addr_in;
	logic [63:0] msg_data_out, msg_rep_data_in;
	logic err_v, req; // Bus error, request seen
	int err_count = 0;
	int n_tests = 0;
	// Rows: config, byte index, expected input byte
	logic [23:0] rows [23] = '{24'h190012, 24'h190134, 24'h190256,
		24'h190378, 24'h19040f, 24'h1905a0, 24'h190600,
		24'h81029a, 24'h810401, 24'h810590,
		24'h030200, 24'h030400, 24'h030633, 24'h030844,
		24'h030a9a, 24'h030c0f, 24'h030e55, 24'h031d00,
		24'h1b0256, 24'h1b0522, 24'h0d029a, 24'h0d0c00,
		24'h1a0000};
	fieldbus_io_image_mapper #(.FWD_CYCLES(40)) dut_u (.*);
	fb_master_model m_u (.clock_in(clock_in), .rx_valid_out(rx_valid_in),
		.rx_byte_out(rx_byte_in), .rx_last_out(rx_last_in),
		.tx_rd_out(tx_rd_in), .tx_index_out(tx_index_in),
		.tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out));
	// Clock at 100 ns
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// Counts, verdict, end
	task stop_test;
		$display("Checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// One APB transfer, waits for ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		// Sample at the rising edge; values seen are those before it
		for (k = 0; k < 20; k++) begin
			@(posedge clock_in);
			if (pready_out === 1'b1) break;
		end
		rd_v = prdata_out;
		err_v = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (k == 20) begin
			err_count++;
			$display("ERROR pready exp 1 got 0");
			stop_test();
		end
	endtask : apb
	// Wait for the command update pulse
	task wait_upd;
		int k;
		for (k = 0; k < 60; k++) begin
			@(negedge clock_in);
			if (cmd_update_out === 1'b1) break;
		end
		req = msg_req_out;
		if (k == 60) begin
			err_count++;
			$display("ERROR cmd_update exp 1 got 0");
			stop_test();
		end
	endtask : wait_upd
	// Main sequence
	initial begin
		{srst_in, psel_in, penable_in, pwrite_in, msg_done_in} = 5'h10;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		{drive_status_in, motor_speed_in} = 32'h12345678;
		{output_freq_in, output_current_in} = 32'h9abc0fa0;
		{torque_monitor_in, encoder_count_in} = 32'h22223333;
		{freq_ref_monitor_in, analog_in_in} = 32'h44445555;
		{msg_rep_func_in, msg_rep_count_in, msg_rep_addr_in} = 32'h0;
		msg_rep_data_in = 64'h0;
		repeat (16) @(posedge clock_in);
		srst_in <= 1'b0;
		`CHK("reset", 16'h0000, op_command_out | torque_ref_out)
		apb(1'b0, image_map_pkg::REG_CONFIG, 32'h0);
		`CHK("config", 32'h0, rd_v)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK("slverr", 1'b1, err_v)
		apb(1'b1, image_map_pkg::REG_FUNC, 32'h00000f00);
		apb(1'b0, image_map_pkg::REG_FUNC, 32'h0);
		`CHK("func", 32'h00000f00, rd_v)
		$display("Test reset done");
		foreach (rows[i]) begin
			apb(1'b1, image_map_pkg::REG_CONFIG, {24'h0, rows[i][23:16]});
			m_u.get(rows[i][12:8], b);
			`CHK("tx_byte", rows[i][7:0], b)
		end
		$display("Test rows done");
		apb(1'b1, image_map_pkg::REG_CONFIG, 32'h39);
		m_u.send(6, 8'h11, 1'b1);
		wait_upd();
		`CHK("op", 16'h1112, op_command_out)
		`CHK("freq", 16'h1314, freq_ref_out)
		`CHK("tlim", 16'h1516, torque_limit_out)
		$display("Test basic done");
		apb(1'b1, image_map_pkg::REG_CONFIG, 32'h7b);
		m_u.send(32, 8'ha0, 1'b1);
		wait_upd();
		`CHK("req", 1'b1, req)
		`CHK("op", 16'ha0a1, op_command_out)
		`CHK("tref", 16'ha4a5, torque_ref_out)
		`CHK("comp", 16'ha6a7, torque_comp_out)
		`CHK("ao", 32'haaabacad, {analog_out1_out, analog_out2_out})
		`CHK("dout", 3'h4, {relay_out, open_collector1_out,
			open_collector2_out})
		`CHK("msg", 32'hb0b1b2b3, {msg_func_out, msg_addr_out,
			msg_count_out})
		`CHK("data", 64'hb4b5b6b7b8b9babb, msg_data_out)
		@(posedge clock_in);
		msg_done_in <= 1'b1;
		msg_rep_func_in <= 8'h03;
		msg_rep_data_in <= 64'hc1c2c3c4c5c6c7c8;
		@(posedge clock_in);
		msg_done_in <= 1'b0;
		m_u.get(5'd16, b);
		`CHK("rep_func", 8'h03, b)
		m_u.get(5'd20, b);
		`CHK("rep_data", 8'hc1, b)
		m_u.get(5'd31, b);
		`CHK("hs", 8'hbf, b)
		m_u.send(32, 8'ha0, 1'b1);
		wait_upd();
		`CHK("req", 1'b0, req)
		$display("Test ext1 done");
		apb(1'b1, image_map_pkg::REG_CONFIG, 32'h3d);
		m_u.send(12, 8'h70, 1'b1);
		wait_upd();
		`CHK("req2", 1'b1, req)
		`CHK("op2", 16'h7071, op_command_out)
		`CHK("msg2", 32'h74757677, {msg_func_out, msg_addr_out,
			msg_count_out})
		`CHK("data2", 64'h7879000000000000, msg_data_out)
		`CHK("tlim2", 16'h1516, torque_limit_out)
		$display("Test ext2 done");
		apb(1'b1, image_map_pkg::REG_CONFIG, 32'h39);
		m_u.send(2, 8'h40, 1'b0);
		wait_upd();
		`CHK("op", 16'h4041, op_command_out)
		apb(1'b1, image_map_pkg::REG_CONFIG, 32'h1a);
		m_u.send(6, 8'h60, 1'b1);
		repeat (8) @(posedge clock_in);
		`CHK("op", 16'h4041, op_command_out)
		$display("Test partial done");
		@(posedge clock_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		`CHK("rst_op", 16'h0000, op_command_out)
		apb(1'b0, image_map_pkg::REG_CONFIG, 32'h0);
		`CHK("rst_cfg", 32'h0, rd_v)
		$display("Test mid reset done");
		stop_test();
	end
endmodule : tb
bind fieldbus_io_image_mapper img_map_asserts chk_u (.*);
